/* design/iig_io_interrupt_group.sv */
`timescale 1ns/1ps
module iig_io_interrupt_group #(
  parameter int N_GROUPS = 12
) (
  // Clock and control
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Register port
  input wire iig_pkg::iig_bus_type bus,
  output logic [iig_pkg::IIG_DATA_W-1:0] rdata,
  // Source requests, one byte per group, bit 0 unused
  input wire logic [iig_pkg::IIG_NUM_GROUPS-1:0][iig_pkg::IIG_DATA_W-1:0] src_req,
  // CPU side
  input wire logic cpu_accept,
  input wire logic [iig_pkg::IIG_VEC_W-1:0] cpu_accept_vector,
  output logic irq_req,
  output logic [iig_pkg::IIG_VEC_W-1:0] irq_vector,
  output logic [iig_pkg::IIG_LEVEL_W-1:0] irq_level,
  // DMA side
  output logic [iig_pkg::IIG_NUM_GROUPS-1:0] dma_trigger
);
  import iig_pkg::*;

  initial begin
    if (N_GROUPS < 1 || N_GROUPS > IIG_NUM_GROUPS) begin
      $error("iig_io_interrupt_group: N_GROUPS must be 1 to 12");
    end
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  iig_core_type state_q;
  iig_core_type state_d;
  logic [IIG_NUM_GROUPS-1:0] grp_req;
  logic [IIG_NUM_GROUPS-1:0] grp_rise;

  // ----------------------------------------
  // Group request and its edge
  // ----------------------------------------
  always_comb begin
    grp_req = '0;
    for (int g = 0; g < N_GROUPS; g++) begin
      grp_req[g] = |(state_q.grp[g].flags & state_q.grp[g].enable & IIG_FLAG_STORE_MASK);
    end
  end

  iig_req_edge #(
    .WIDTH(IIG_NUM_GROUPS)
  ) u_edge (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .level(grp_req),
    .rise(grp_rise)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic route;
    logic found;
    route = 1'b0;
    found = 1'b0;
    state_d = state_q;
    state_d.dma_trig = '0;
    state_d.irq_req = 1'b0;
    state_d.irq_vector = IIG_VECTOR_BASE;
    state_d.irq_level = IIG_LEVEL_RESET;
    for (int g = 0; g < N_GROUPS; g++) begin
      route = state_q.grp[g].enable[IIG_ROUTE_BIT];
      // Software writes
      if (bus.wr && iig_hit(bus.addr, IIG_FLAGS_BASE, g)) begin
        state_d.grp[g].flags = state_q.grp[g].flags & bus.wdata & IIG_FLAG_STORE_MASK;
      end
      if (bus.wr && iig_hit(bus.addr, IIG_ENABLE_BASE, g)) begin
        state_d.grp[g].enable = bus.wdata;
      end
      if (bus.wr && iig_hit(bus.addr, IIG_CONTROL_BASE, g)) begin
        state_d.grp[g].level = bus.wdata[IIG_LEVEL_LSB +: IIG_LEVEL_W];
        state_d.grp[g].pending = state_q.grp[g].pending & bus.wdata[IIG_PEND_BIT];
      end
      // Acceptance clears pending only; flags stay
      if (cpu_accept && cpu_accept_vector == iig_vector(g)) begin
        state_d.grp[g].pending = 1'b0;
      end
      // Source events win over a clearing write
      state_d.grp[g].flags = (state_d.grp[g].flags | src_req[g]) & IIG_FLAG_STORE_MASK;
      // Only a new rise of the group request sets pending
      if (grp_rise[g]) begin
        state_d.grp[g].pending = 1'b1;
        state_d.dma_trig[g] = ~route;
      end
      // Lowest group routed to the CPU is presented first
      if (!found && route && state_q.grp[g].pending) begin
        found = 1'b1;
        state_d.irq_req = 1'b1;
        state_d.irq_vector = iig_vector(g);
        state_d.irq_level = state_q.grp[g].level;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= '0;
      for (int g = 0; g < IIG_NUM_GROUPS; g++) begin
        state_q.grp[g].flags <= IIG_FLAGS_RESET;
        state_q.grp[g].enable <= IIG_ENABLE_RESET;
        state_q.grp[g].level <= IIG_LEVEL_RESET;
      end
      state_q.irq_vector <= IIG_VECTOR_BASE;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  iig_read_port u_read (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .rd(bus.rd),
    .addr(bus.addr),
    .grp(state_q.grp),
    .rdata(rdata)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign irq_req = state_q.irq_req;
  assign irq_vector = state_q.irq_vector;
  assign irq_level = state_q.irq_level;
  assign dma_trigger = state_q.dma_trig;
endmodule

/* design/iig_pkg.sv */
// How it works
// - The twelve groups answer on vector numbers 44 through 55, one number per group in order.
// - A request from a source sets that source's flag bit in the group flag register.
// - A set flag whose enable mask bit is 1 sets the group's pending bit.
// - While an enabled flag of the group stays set, further enabled flags are still set in the flag register but make no new event.
// - CPU acceptance of a group interrupt leaves every source flag set.
// - Until software clears the set flags, new requests of that group make no new pending event.
package iig_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int IIG_NUM_GROUPS = 12;
  localparam int IIG_DATA_W = 8;
  localparam int IIG_ADDR_W = 6;
  localparam int IIG_VEC_W = 6;
  localparam int IIG_LEVEL_W = 3;

  // ----------------------------------------
  // Vectors
  // ----------------------------------------
  localparam logic [IIG_VEC_W-1:0] IIG_VECTOR_BASE = 6'h2c;
  localparam logic [IIG_VEC_W-1:0] IIG_VECTOR_LAST = 6'h37;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [IIG_ADDR_W-1:0] IIG_FLAGS_BASE = 6'h00;
  localparam logic [IIG_ADDR_W-1:0] IIG_ENABLE_BASE = 6'h10;
  localparam logic [IIG_ADDR_W-1:0] IIG_CONTROL_BASE = 6'h20;

  // ----------------------------------------
  // Field positions and masks
  // ----------------------------------------
  localparam int IIG_FLAG_FIXED_BIT = 0;
  localparam int IIG_ROUTE_BIT = 0;
  localparam int IIG_PEND_BIT = 3;
  localparam int IIG_LEVEL_LSB = 0;
  localparam logic [IIG_DATA_W-1:0] IIG_FLAG_STORE_MASK = 8'hfe;
  localparam logic [IIG_DATA_W-1:0] IIG_UNMAPPED_READ = 8'h00;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [IIG_DATA_W-1:0] IIG_FLAGS_RESET = 8'h00;
  localparam logic [IIG_DATA_W-1:0] IIG_ENABLE_RESET = 8'h00;
  localparam logic [IIG_LEVEL_W-1:0] IIG_LEVEL_RESET = 3'h0;
  localparam logic [IIG_DATA_W-1:0] IIG_RDATA_RESET = 8'h00;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [IIG_ADDR_W-1:0] addr;
    logic [IIG_DATA_W-1:0] wdata;
  } iig_bus_type;

  typedef struct packed {
    logic [IIG_DATA_W-1:0] flags;
    logic [IIG_DATA_W-1:0] enable;
    logic [IIG_LEVEL_W-1:0] level;
    logic pending;
  } iig_group_type;

  typedef iig_group_type [IIG_NUM_GROUPS-1:0] iig_group_arr_type;

  typedef struct packed {
    iig_group_arr_type grp;
    logic irq_req;
    logic [IIG_VEC_W-1:0] irq_vector;
    logic [IIG_LEVEL_W-1:0] irq_level;
    logic [IIG_NUM_GROUPS-1:0] dma_trig;
  } iig_core_type;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic iig_hit(logic [IIG_ADDR_W-1:0] addr,
                                   logic [IIG_ADDR_W-1:0] base, int g);
    return addr == (base + IIG_ADDR_W'(g));
  endfunction

  function automatic logic [IIG_VEC_W-1:0] iig_vector(int g);
    return IIG_VECTOR_BASE + IIG_VEC_W'(g);
  endfunction

endpackage

/* design/iig_req_edge.sv */
`timescale 1ns/1ps
module iig_req_edge #(
  parameter int WIDTH = 12
) (
  // Clock and control
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Levels and their rising edges
  input wire logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);
  import iig_pkg::*;

  initial begin
    if (WIDTH < 1) $error("iig_req_edge: WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [WIDTH-1:0] prev;
  } iig_edge_state_type;

  iig_edge_state_type state_q;
  iig_edge_state_type state_d;

  always_comb begin
    state_d = state_q;
    state_d.prev = level;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= '0;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // Only a 0 to 1 change of the group request counts
  assign rise = level & ~state_q.prev;
endmodule

/* design/iig_read_port.sv */
`timescale 1ns/1ps
module iig_read_port (
  // Clock and control
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Read request and register contents
  input wire logic rd,
  input wire logic [iig_pkg::IIG_ADDR_W-1:0] addr,
  input wire iig_pkg::iig_group_arr_type grp,
  // Read data, one cycle after the strobe
  output logic [iig_pkg::IIG_DATA_W-1:0] rdata
);
  import iig_pkg::*;

  typedef struct packed {
    logic [IIG_DATA_W-1:0] rdata;
  } iig_rd_state_type;

  iig_rd_state_type state_q;
  iig_rd_state_type state_d;

  always_comb begin
    state_d = state_q;
    state_d.rdata = IIG_UNMAPPED_READ;
    if (rd) begin
      for (int g = 0; g < IIG_NUM_GROUPS; g++) begin
        if (iig_hit(addr, IIG_FLAGS_BASE, g)) begin
          state_d.rdata = grp[g].flags & IIG_FLAG_STORE_MASK;
          state_d.rdata[IIG_FLAG_FIXED_BIT] = 1'b1;
        end
        if (iig_hit(addr, IIG_ENABLE_BASE, g)) begin
          state_d.rdata = grp[g].enable;
        end
        if (iig_hit(addr, IIG_CONTROL_BASE, g)) begin
          state_d.rdata = '0;
          state_d.rdata[IIG_LEVEL_LSB +: IIG_LEVEL_W] = grp[g].level;
          state_d.rdata[IIG_PEND_BIT] = grp[g].pending;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= '{rdata: IIG_RDATA_RESET};
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  assign rdata = state_q.rdata;
endmodule

/* tb/iig_host_model.sv */
`timescale 1ns/1ps
module iig_host_model (
  // Clock and control
  input wire logic mclk,
  input wire logic rst,
  input wire logic go,
  // CPU side
  input wire logic irq_req,
  input wire logic [iig_pkg::IIG_VEC_W-1:0] irq_vector,
  output logic cpu_accept,
  output logic [iig_pkg::IIG_VEC_W-1:0] cpu_accept_vector,
  output int acc_count,
  // DMA side
  input wire logic [iig_pkg::IIG_NUM_GROUPS-1:0] dma_trigger,
  output int dma_count
);
  logic [2:0] hold_q;
  // Accept, then wait until the request line has settled
  always_ff @(posedge mclk) begin
    if (rst) begin
      cpu_accept <= 1'b0;
      cpu_accept_vector <= 6'h2c;
      hold_q <= 3'h0;
      acc_count <= 0;
      dma_count <= 0;
    end else begin
      cpu_accept <= 1'b0;
      dma_count <= dma_count + $countones(dma_trigger);
      if (hold_q != 3'h0) begin
        hold_q <= hold_q - 3'h1;
      end else if (go && irq_req) begin
        cpu_accept <= 1'b1;
        cpu_accept_vector <= irq_vector;
        hold_q <= 3'h4;
        acc_count <= acc_count + 1;
      end
    end
  end
endmodule

/* tb/iig_properties.sv */
`timescale 1ns/1ps
module iig_properties (
  // Clock and control
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Register port
  input wire iig_pkg::iig_bus_type bus,
  input wire logic [iig_pkg::IIG_DATA_W-1:0] rdata,
  // Sources and outputs
  input wire logic [iig_pkg::IIG_NUM_GROUPS-1:0][iig_pkg::IIG_DATA_W-1:0] src_req,
  input wire logic cpu_accept,
  input wire logic irq_req,
  input wire logic [iig_pkg::IIG_VEC_W-1:0] irq_vector,
  input wire logic [iig_pkg::IIG_LEVEL_W-1:0] irq_level,
  input wire logic [iig_pkg::IIG_NUM_GROUPS-1:0] dma_trigger
);
  import iig_pkg::*;
  logic any_src;
  assign any_src = |src_req;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_vrng; irq_req |-> irq_vector inside {[6'h2c:6'h37]}; endproperty
  a_vrng: assert property (p_vrng) else $error("vector range");
  property p_idle; !irq_req |-> irq_vector == 6'h2c && irq_level == 3'h0; endproperty
  a_idle: assert property (p_idle) else $error("idle vector");
  property p_rzero; (ce && !bus.rd) ##1 ce |-> rdata == 8'h00; endproperty
  a_rzero: assert property (p_rzero) else $error("read data idle");
  property p_bit0; ce && bus.rd && bus.addr < 6'h0c |=> rdata[0]; endproperty
  a_bit0: assert property (p_bit0) else $error("flag bit 0");
  property p_dpul; |dma_trigger |=> (dma_trigger & $past(dma_trigger)) == 12'h000; endproperty
  a_dpul: assert property (p_dpul) else $error("dma pulse");
  property p_dsrc;
    |dma_trigger |-> $past(any_src, 2) || $past(bus.wr) || $past(bus.wr, 2);
  endproperty
  a_dsrc: assert property (p_dsrc) else $error("dma cause");
  property p_hold;
    irq_req && !cpu_accept && !$past(cpu_accept) && !bus.wr && !$past(bus.wr) |=> irq_req;
  endproperty
  a_hold: assert property (p_hold) else $error("pending lost");
  property p_echo;
    (ce && bus.wr && bus.addr == 6'h10) ##1 (ce && bus.rd && bus.addr == 6'h10)
      |=> rdata == $past(bus.wdata, 2);
  endproperty
  a_echo: assert property (p_echo) else $error("enable readback");
  c_irq: cover property (irq_req ##1 cpu_accept);
  c_dma: cover property (|dma_trigger);
  c_rd: cover property (bus.rd ##1 rdata != 8'h00);
endmodule
bind iig_io_interrupt_group iig_properties u_props (.mclk(mclk), .rst(rst), .ce(ce),
  .bus(bus), .rdata(rdata), .src_req(src_req), .cpu_accept(cpu_accept), .irq_req(irq_req),
  .irq_vector(irq_vector), .irq_level(irq_level), .dma_trigger(dma_trigger));

/* tb/iig_io_interrupt_group_tb.sv */
`timescale 1ns/1ps
module iig_io_interrupt_group_tb;
  import iig_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic go = 1'b0;
  logic ce = 1'b1;
  iig_bus_type bus = '0;
  logic [IIG_NUM_GROUPS-1:0][IIG_DATA_W-1:0] src_req = '0;
  logic [IIG_DATA_W-1:0] rdata;
  logic cpu_accept;
  logic irq_req;
  logic [IIG_VEC_W-1:0] cpu_accept_vector;
  logic [IIG_VEC_W-1:0] irq_vector;
  logic [IIG_LEVEL_W-1:0] irq_level;
  logic [IIG_NUM_GROUPS-1:0] dma_trigger;
  int acc_count;
  int dma_count;
  int miscompares = 0;
  int checks = 0;
  always #20 mclk = ~mclk;
  iig_io_interrupt_group uut (.mclk(mclk), .rst(rst), .ce(ce), .bus(bus), .rdata(rdata),
    .src_req(src_req), .cpu_accept(cpu_accept), .cpu_accept_vector(cpu_accept_vector),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_level(irq_level),
    .dma_trigger(dma_trigger));
  iig_host_model partner (.mclk(mclk), .rst(rst), .go(go), .irq_req(irq_req),
    .irq_vector(irq_vector), .cpu_accept(cpu_accept), .cpu_accept_vector(cpu_accept_vector),
    .acc_count(acc_count), .dma_trigger(dma_trigger), .dma_count(dma_count));
  task automatic summarize;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= {1'b1, 1'b0, a, d};
    @(posedge mclk);
    bus <= '0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge mclk);
    bus <= {1'b0, 1'b1, a, 8'h00};
    @(posedge mclk);
    bus <= '0;
    #1 chk("rdata", e, rdata);
  endtask
  task automatic pulse(input int g, input int k);
    @(posedge mclk);
    src_req[g][k] <= 1'b1;
    @(posedge mclk);
    src_req[g][k] <= 1'b0;
  endtask
  task automatic wait_irq(input logic e);
    int n;
    n = 0;
    while (irq_req !== e && n < 20) begin
      @(posedge mclk);
      #1 n++;
    end
    chk("irq_req", {7'h00, e}, {7'h00, irq_req});
    if (irq_req !== e)
      summarize();
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rd(6'h00, 8'h01);
    rd(6'h10, 8'h00);
    rd(6'h20, 8'h00);
    rd(6'h3f, 8'h00);
    wr(6'h10, 8'h07);
    pulse(0, 1);
    wait_irq(1'b1);
    chk("vector", 8'h2c, {2'b00, irq_vector});
    pulse(0, 2);
    rd(6'h00, 8'h07);
    rd(6'h20, 8'h08);
    @(posedge mclk);
    go <= 1'b1;
    wait_irq(1'b0);
    chk("accepts", 8'h01, 8'(acc_count));
    rd(6'h00, 8'h07);
    pulse(0, 1);
    rd(6'h20, 8'h00);
    wr(6'h00, 8'hfd);
    rd(6'h00, 8'h05);
    wr(6'h00, 8'h01);
    for (int g = 1; g < 12; g++) begin
      wr(IIG_ENABLE_BASE + 6'(g), 8'h03);
      pulse(g, 1);
      wait_irq(1'b1);
      chk("vector", 8'(44 + g), {2'b00, irq_vector});
      wait_irq(1'b0);
      wr(IIG_FLAGS_BASE + 6'(g), 8'h01);
    end
    wr(6'h15, 8'h02);
    pulse(5, 1);
    repeat (3) @(posedge mclk);
    #1;
    chk("dma", 8'h01, 8'(dma_count));
    chk("irq_req", 8'h00, {7'h00, irq_req});
    wr(6'h05, 8'hff);
    rd(6'h05, 8'h03);
    @(posedge mclk);
    bus <= {1'b1, 1'b0, 6'h10, 8'ha5};
    rd(6'h10, 8'ha5);
    @(posedge mclk);
    ce <= 1'b0;
    pulse(5, 2);
    ce <= 1'b1;
    rd(6'h05, 8'h03);
    rd(6'h25, 8'h08);
    wr(6'h25, 8'h00);
    rd(6'h25, 8'h00);
    wr(6'h20, 8'h05);
    rd(6'h20, 8'h05);
    pulse(0, 2);
    wait_irq(1'b1);
    chk("level", 8'h05, {5'h00, irq_level});
    wait_irq(1'b0);
    chk("accepts", 8'h0d, 8'(acc_count));
    summarize();
  end
endmodule
